// File: eabc_regs.sv
// Per-area external bus configuration bank with an APB slave and access timer.
// Assumes an APB master on pclk and a sequencer that pulses access_start.
// Operation
// R1: Width register holds high bits 15..8 and low bits 7..0, one per area.
// R2: High 0 low 1 is 16-bit, both 1 is 8-bit; low 0 refused.
// R3: Width resets to all ones, area-0 high bit cleared on 16-bit boot.
// R4: Software keeps byte-control memory areas out of 8-bit mode.
// R5: Access-state bits 15..8 pick states for areas 7..0, reset to 1.
// R6: Access-state bit 0 gives two-state access without any waits.
// R7: Access-state bit 1 gives three-state access with waits allowed.
// R8: Access-state bits 7..0 read zero and ignore writes.
// R9: Two wait registers hold four 3-bit fields each, gaps read zero.
// R10: Wait field inserts 0 to 7 waits, only in three-state mode.
// R11: Wait fields reset to 111; new values apply to later accesses.
`timescale 1ns/1ps
module eabc_regs
import eabc_pkg::*;
(
    input  wire logic                                pclk,
    input  wire logic                                presetn,
    input  wire logic                                ce,
    input  wire logic                                boot_bus_16,
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [eabc_pkg::ADDR_W-1:0]         paddr,
    input  wire logic [eabc_pkg::DATA_W-1:0]         pwdata,
    input  wire logic [3:0]                          pstrb,
    output logic [eabc_pkg::DATA_W-1:0]              prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    input  wire logic                                access_start,
    input  wire logic [2:0]                          access_area,
    output logic                                     access_busy,
    output logic                                     access_done,
    output logic                                     acc_bus8,
    output logic                                     acc_three_state,
    output logic                                     acc_wait_en,
    output logic [eabc_pkg::WAIT_W-1:0]              acc_wait_count,
    output logic [eabc_pkg::AREA_N-1:0]              area_bus8,
    output logic [eabc_pkg::AREA_N-1:0]              area_three_state
);
    import eabc_pkg::*;

    typedef struct packed {
        logic [REG_W-1:0]         bus_width;
        logic [AREA_N-1:0]        acc_state;
        logic [AREA_N*WAIT_W-1:0] wait_counts;
        logic [2:0]               strap_cnt;
        logic                     strap_done;
        logic [DATA_W-1:0]        rdata;
        eabc_seq_t                seq;
        logic [CNT_W-1:0]         cnt;
        logic                     done;
        logic                     lat_bus8;
        logic                     lat_three;
        logic                     lat_wait_en;
        logic [WAIT_W-1:0]        lat_wait;
    } eabc_state_t;

    eabc_state_t st_reg;
    eabc_state_t st_next;

    logic                 boot16_sync;
    logic                 cfg_bus8;
    logic                 cfg_three;
    logic                 cfg_wait_en;
    logic [WAIT_W-1:0]    cfg_wait;
    logic [CNT_W-1:0]     cfg_total;
    logic                 setup_phase;
    logic                 access_phase;
    logic                 addr_hit;
    logic [REG_W-1:0]     merged;
    logic                 width_refused;

    // Packs four 3-bit wait fields into a 16-bit register image.
    function automatic logic [REG_W-1:0] pack_wait(input logic [4*WAIT_W-1:0] f);
        logic [REG_W-1:0] r;
        r = '0;
        for (int i = 0; i < 4; i++)
        begin
            r[i*WAIT_FIELD_PITCH +: WAIT_W] = f[i*WAIT_W +: WAIT_W];
        end
        return r;
    endfunction

    // Extracts four 3-bit wait fields from a 16-bit register image.
    function automatic logic [4*WAIT_W-1:0] unpack_wait(input logic [REG_W-1:0] r);
        logic [4*WAIT_W-1:0] f;
        f = '0;
        for (int i = 0; i < 4; i++)
        begin
            f[i*WAIT_W +: WAIT_W] = r[i*WAIT_FIELD_PITCH +: WAIT_W];
        end
        return f;
    endfunction

    // Returns the 16-bit image of the register at an offset.
    function automatic logic [REG_W-1:0] read_image(input eabc_state_t s, input logic [ADDR_W-1:0] a);
        logic [REG_W-1:0] r;
        r = '0;
        case (a)
            OFS_BUS_WIDTH:  r = s.bus_width;
            // R8: low byte reads zero.
            OFS_ACC_STATE:  r = {s.acc_state, 8'h00};
            // R9: gap bits read zero.
            OFS_UPPER_WAIT: r = pack_wait(s.wait_counts[AREA_N*WAIT_W-1 -: 4*WAIT_W]);
            OFS_LOWER_WAIT: r = pack_wait(s.wait_counts[4*WAIT_W-1:0]);
            default:        r = '0;
        endcase
        return r;
    endfunction

    eabc_sync3 u_boot_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .din     (boot_bus_16),
        .dout    (boot16_sync)
    );

    eabc_area_cfg u_area_cfg
    (
        .bus_width    (st_reg.bus_width),
        .acc_state    (st_reg.acc_state),
        .wait_counts  (st_reg.wait_counts),
        .area         (access_area),
        .bus8         (cfg_bus8),
        .three_state  (cfg_three),
        .wait_en      (cfg_wait_en),
        .wait_count   (cfg_wait),
        .total_states (cfg_total)
    );

    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable & st_reg.strap_done;
    assign addr_hit     = (paddr == OFS_BUS_WIDTH) | (paddr == OFS_ACC_STATE) |
                          (paddr == OFS_UPPER_WAIT) | (paddr == OFS_LOWER_WAIT);

    // Merges write data into the addressed register by byte strobe.
    always_comb
    begin
        merged = read_image(st_reg, paddr);
        if (pstrb[0])
        begin
            merged[7:0] = pwdata[7:0];
        end
        if (pstrb[1])
        begin
            merged[15:8] = pwdata[15:8];
        end
    end

    // R2: refuse clearing a low bit.
    assign width_refused = pwrite & (paddr == OFS_BUS_WIDTH) &
                           (merged[WIDTH_LOW_POS +: AREA_N] != {AREA_N{1'b1}});

    always_comb
    begin
        st_next = st_reg;
        if (ce)
        begin
            // R3: boot width taken after settling.
            if (!st_reg.strap_done)
            begin
                if (st_reg.strap_cnt == STRAP_SETTLE)
                begin
                    st_next.strap_done = 1'b1;
                    st_next.bus_width = boot16_sync ? BUS_WIDTH_RST_16 : BUS_WIDTH_RST_8;
                end
                else
                begin
                    st_next.strap_cnt = st_reg.strap_cnt + 3'h1;
                end
            end

            if ((setup_phase || (psel && !st_reg.strap_done)) && !pwrite)
            begin
                st_next.rdata = {16'h0000, read_image(st_next, paddr)};
            end

            if (access_phase && pwrite && addr_hit && !width_refused)
            begin
                case (paddr)
                    // R1: full width register written.
                    OFS_BUS_WIDTH:  st_next.bus_width = merged;
                    // R5: state bits in upper byte.
                    OFS_ACC_STATE:  st_next.acc_state = merged[STATE_BIT_POS +: AREA_N];
                    // R9: upper register serves areas 7..4.
                    OFS_UPPER_WAIT: st_next.wait_counts[AREA_N*WAIT_W-1 -: 4*WAIT_W] = unpack_wait(merged);
                    OFS_LOWER_WAIT: st_next.wait_counts[4*WAIT_W-1:0] = unpack_wait(merged);
                    default:        st_next.bus_width = st_reg.bus_width;
                endcase
            end

            st_next.done = 1'b0;
            case (st_reg.seq)
                EABC_IDLE:
                begin
                    if (access_start && st_reg.strap_done)
                    begin
                        // R11: settings frozen at start.
                        st_next.lat_bus8    = cfg_bus8;
                        st_next.lat_three   = cfg_three;
                        st_next.lat_wait_en = cfg_wait_en;
                        st_next.lat_wait    = cfg_wait;
                        st_next.cnt         = cfg_total - 4'h1;
                        st_next.seq         = EABC_RUN;
                    end
                end
                EABC_RUN:
                begin
                    // R10: one cycle per state.
                    if (st_reg.cnt == '0)
                    begin
                        st_next.done = 1'b1;
                        st_next.seq  = EABC_IDLE;
                    end
                    else
                    begin
                        st_next.cnt = st_reg.cnt - 4'h1;
                    end
                end
                default:
                begin
                    st_next.seq = EABC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // R3: all ones until boot width known.
            st_reg.bus_width   <= BUS_WIDTH_RST_8;
            // R5: state bits reset to one.
            st_reg.acc_state   <= ACC_STATE_RST;
            // R11: wait fields reset to 111.
            st_reg.wait_counts <= {AREA_N{WAIT_COUNT_RST}};
            st_reg.strap_cnt   <= '0;
            st_reg.strap_done  <= 1'b0;
            st_reg.rdata       <= '0;
            st_reg.seq         <= EABC_IDLE;
            st_reg.cnt         <= '0;
            st_reg.done        <= 1'b0;
            st_reg.lat_bus8    <= 1'b0;
            st_reg.lat_three   <= 1'b0;
            st_reg.lat_wait_en <= 1'b0;
            st_reg.lat_wait    <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Per-area decoded settings for the sequencer.
    generate
        for (genvar n = 0; n < AREA_N; n++)
        begin : g_area
            assign area_bus8[n]        = st_reg.bus_width[WIDTH_HIGH_POS + n] & st_reg.bus_width[WIDTH_LOW_POS + n];
            assign area_three_state[n] = st_reg.acc_state[n];
        end
    endgenerate

    assign pready          = st_reg.strap_done;
    assign pslverr         = access_phase & (~addr_hit | width_refused);
    assign prdata          = st_reg.rdata;
    assign access_busy     = (st_reg.seq == EABC_RUN);
    assign access_done     = st_reg.done;
    assign acc_bus8        = st_reg.lat_bus8;
    assign acc_three_state = st_reg.lat_three;
    assign acc_wait_en     = st_reg.lat_wait_en;
    assign acc_wait_count  = st_reg.lat_wait;
endmodule

// File: eabc_pkg.sv
// Constants and types shared by the area bus configuration bank.
// Assumes a 32-bit APB register bus and eight external areas.
package eabc_pkg;

    localparam int AREA_N  = 8;
    localparam int WAIT_W  = 3;
    localparam int ADDR_W  = 12;
    localparam int DATA_W  = 32;
    localparam int REG_W   = 16;
    localparam int CNT_W   = 4;

    localparam logic [ADDR_W-1:0] OFS_BUS_WIDTH = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_ACC_STATE = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_UPPER_WAIT = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_LOWER_WAIT = 12'h00C;

    localparam int WIDTH_HIGH_POS = 8;
    localparam int WIDTH_LOW_POS  = 0;
    localparam int STATE_BIT_POS  = 8;
    localparam int WAIT_FIELD_PITCH = 4;

    localparam logic [REG_W-1:0] BUS_WIDTH_RST_8  = 16'hFFFF;
    localparam logic [REG_W-1:0] BUS_WIDTH_RST_16 = 16'hFEFF;
    localparam logic [AREA_N-1:0] ACC_STATE_RST = 8'hFF;
    localparam logic [WAIT_W-1:0] WAIT_COUNT_RST = 3'h7;

    localparam logic [CNT_W-1:0] STATES_TWO   = 4'h2;
    localparam logic [CNT_W-1:0] STATES_THREE = 4'h3;
    localparam logic [2:0]       STRAP_SETTLE = 3'h4;

    typedef enum logic [1:0] {
        EABC_IDLE = 2'b01,
        EABC_RUN  = 2'b10
    } eabc_seq_t;

endpackage

// File: eabc_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to pclk.
`timescale 1ns/1ps
module eabc_sync3
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } eabc_sync_t;

    eabc_sync_t st_reg;
    eabc_sync_t st_next;

    // The first stage feeds only the second one.
    always_comb
    begin
        st_next = st_reg;
        if (ce)
        begin
            st_next.s1 = din;
            st_next.s2 = st_reg.s1;
            st_next.s3 = st_reg.s2;
            if (st_reg.s2 == st_reg.s3)
            begin
                st_next.q = st_reg.s3;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.q;
endmodule

// File: eabc_area_cfg.sv
// Decodes the settings of one selected area from the register contents.
// Assumes registers are held in the bank's internal layout.
`timescale 1ns/1ps
module eabc_area_cfg
import eabc_pkg::*;
(
    input  wire logic [eabc_pkg::REG_W-1:0]         bus_width,
    input  wire logic [eabc_pkg::AREA_N-1:0]        acc_state,
    input  wire logic [eabc_pkg::AREA_N*eabc_pkg::WAIT_W-1:0] wait_counts,
    input  wire logic [2:0]                         area,
    output logic                                    bus8,
    output logic                                    three_state,
    output logic                                    wait_en,
    output logic [eabc_pkg::WAIT_W-1:0]             wait_count,
    output logic [eabc_pkg::CNT_W-1:0]              total_states
);
    import eabc_pkg::*;

    always_comb
    begin
        // R2: both bits set select 8-bit.
        bus8 = bus_width[WIDTH_HIGH_POS + area] & bus_width[WIDTH_LOW_POS + area];
        three_state = acc_state[area];
        wait_en = acc_state[area];
        // R10: waits only in 3-state.
        wait_count = acc_state[area] ? wait_counts[area*WAIT_W +: WAIT_W] : '0;
        // R6: two states, no waits.
        // R7: three states plus waits.
        total_states = acc_state[area] ? STATES_THREE + {1'b0, wait_count} : STATES_TWO;
    end
endmodule

// File: eabc_regs_props.sv
// Concurrent checks on the ports of the area bus configuration bank.
// Assumes one pclk domain and the asynchronous active-low presetn.
`timescale 1ns/1ps
module eabc_regs_props
(
    input wire logic                          pclk,
    input wire logic                          presetn,
    input wire logic                          ce,
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pwrite,
    input wire logic [eabc_pkg::ADDR_W-1:0]   paddr,
    input wire logic [eabc_pkg::DATA_W-1:0]   pwdata,
    input wire logic [3:0]                    pstrb,
    input wire logic [eabc_pkg::DATA_W-1:0]   prdata,
    input wire logic                          pready,
    input wire logic                          pslverr,
    input wire logic                          access_start,
    input wire logic [2:0]                    access_area,
    input wire logic                          access_busy,
    input wire logic                          access_done,
    input wire logic                          acc_three_state,
    input wire logic                          acc_wait_en,
    input wire logic [eabc_pkg::WAIT_W-1:0]   acc_wait_count,
    input wire logic [eabc_pkg::AREA_N-1:0]   area_bus8,
    input wire logic [eabc_pkg::AREA_N-1:0]   area_three_state
);
    import eabc_pkg::*;
    logic [3:0] busy_cnt_reg;
    logic       wr_ok;
    logic       rd_ok;
    logic       go;
    assign wr_ok = psel && penable && pready && pwrite && ce && !pslverr;
    assign rd_ok = psel && penable && pready && !pwrite;
    assign go = access_start && !access_busy && pready && ce;
    // Counts the cycles of the running access.
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            busy_cnt_reg <= 4'h0;
        else
            busy_cnt_reg <= access_busy ? busy_cnt_reg + 4'h1 : 4'h0;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_RD_HIGH_ZERO: assert property (rd_ok |-> prdata[31:16] == 16'h0000)
        else $error("register read shows upper half set");
    AST_STATE_RSVD: assert property (rd_ok && paddr == OFS_ACC_STATE |-> prdata[7:0] == 8'h00)
        else $error("access state low byte not zero");
    AST_WAIT_GAPS: assert property (rd_ok && paddr[3] |-> (prdata[15:0] & 16'h8888) == 16'h0000)
        else $error("wait register gap bit set");
    AST_WIDTH_MAP: assert property (wr_ok && paddr == OFS_BUS_WIDTH && pstrb[1:0] == 2'h3
        |=> area_bus8 == ($past(pwdata[15:8]) & $past(pwdata[7:0])))
        else $error("8-bit flags do not follow width write");
    AST_WIDTH_REFUSE: assert property (psel && penable && pready && pwrite && paddr == OFS_BUS_WIDTH
        && pstrb[0] && pwdata[7:0] != 8'hFF |-> pslverr ##1 $stable(area_bus8))
        else $error("width write with low bit 0 not refused");
    AST_STATE_MAP: assert property (wr_ok && paddr == OFS_ACC_STATE && pstrb[1]
        |=> area_three_state == $past(pwdata[15:8]))
        else $error("state flags do not follow write");
    AST_TWO_STATE: assert property (go && !area_three_state[access_area]
        |=> access_busy && !acc_three_state && !acc_wait_en && acc_wait_count == 3'h0
        ##1 access_busy ##1 !access_busy && access_done)
        else $error("two-state access wrong");
    AST_THREE_STATE: assert property (go && area_three_state[access_area]
        |=> (access_busy && acc_three_state && acc_wait_en)[*3])
        else $error("three-state access wrong");
    AST_WAIT_LEN: assert property ($fell(access_busy) |-> access_done &&
        busy_cnt_reg == (acc_three_state ? 4'h3 + {1'b0, acc_wait_count} : 4'h2))
        else $error("access length wrong");
endmodule
bind eabc_regs eabc_regs_props u_eabc_regs_props (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .access_start, .access_area, .access_busy, .access_done,
    .acc_three_state, .acc_wait_en, .acc_wait_count, .area_bus8, .area_three_state);

// File: tb_eabc_regs.sv
// Self-checking bench for the area bus configuration bank.
// Assumes an APB slave that stalls only until the boot strap has settled.
`timescale 1ns/1ps
module tb_eabc_regs;
    import eabc_pkg::*;
    logic                 pclk = 1'b0;
    logic                 presetn = 1'b0;
    logic                 ce = 1'b1;
    logic                 boot_bus_16 = 1'b1;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [ADDR_W-1:0]    paddr = 12'h000;
    logic [DATA_W-1:0]    pwdata = 32'h0;
    logic [3:0]           pstrb = 4'hF;
    logic [DATA_W-1:0]    prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 access_start = 1'b0;
    logic [2:0]           access_area = 3'h0;
    logic                 access_busy;
    logic                 access_done;
    logic                 acc_bus8;
    logic                 acc_three_state;
    logic                 acc_wait_en;
    logic [WAIT_W-1:0]    acc_wait_count;
    logic [AREA_N-1:0]    area_bus8;
    logic [AREA_N-1:0]    area_three_state;
    logic [DATA_W-1:0]    rd;
    logic                 err;
    logic [15:0]          wexp = 16'h3CFF;
    logic [7:0]           st = 8'h5A;
    logic [2:0]           wtab [8] = '{3'h3, 3'h2, 3'h1, 3'h0, 3'h4, 3'h2, 3'h5, 3'h7};
    int                   fails = 0;
    int                   samples_checked = 0;
    always #5 pclk = ~pclk;
    eabc_regs u_eabc_regs (.pclk, .presetn, .ce, .boot_bus_16, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .access_start, .access_area, .access_busy, .access_done, .acc_bus8,
        .acc_three_state, .acc_wait_en, .acc_wait_count, .area_bus8, .area_three_state);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h1, {31'h0, pready});
        @(posedge pclk);
    endtask
    task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0, 4'hF);
        chk(what, exp, rd);
        chk({what, " err"}, {31'h0, e}, {31'h0, err});
    endtask
    task automatic wchk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic e);
        apb(1'b1, a, d, s);
        chk("write err", {31'h0, e}, {31'h0, err});
    endtask
    task automatic acc(input logic [2:0] a);
        int n;
        int busy_n;
        logic ts;
        logic [2:0] wc;
        busy_n = 0;
        ts = st[a];
        wc = ts ? wtab[a] : 3'h0;
        access_start <= 1'b1;
        access_area <= a;
        @(posedge pclk);
        access_start <= 1'b0;
        for (n = 0; n < 20 && access_done !== 1'b1; n++)
        begin
            @(posedge pclk);
            busy_n += (access_busy === 1'b1);
        end
        chk("busy cycles", ts ? 3 + wc : 2, busy_n);
        chk("three state", {31'h0, ts}, {31'h0, acc_three_state});
        chk("wait enable", {31'h0, ts}, {31'h0, acc_wait_en});
        chk("wait count", {29'h0, wc}, {29'h0, acc_wait_count});
        chk("bus8", {31'h0, wexp[{1'b1, a}] & wexp[a]}, {31'h0, acc_bus8});
    endtask
    task automatic do_reset(input logic b);
        boot_bus_16 <= b;
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        do_reset(1'b1);
        rchk("width", OFS_BUS_WIDTH, 32'h0000FEFF, 1'b0);
        rchk("state", OFS_ACC_STATE, 32'h0000FF00, 1'b0);
        rchk("upper wait", OFS_UPPER_WAIT, 32'h00007777, 1'b0);
        rchk("lower wait", OFS_LOWER_WAIT, 32'h00007777, 1'b0);
        rchk("unmapped", 12'h010, 32'h0, 1'b1);
        chk("area bus8", 32'hFE, {24'h0, area_bus8});
        $display("test reset values done");
        wchk(OFS_BUS_WIDTH, 32'h0000A5FF, 4'h3, 1'b0);
        chk("area bus8", 32'hA5, {24'h0, area_bus8});
        wchk(OFS_BUS_WIDTH, 32'h000012FE, 4'h3, 1'b1);
        wchk(OFS_BUS_WIDTH, 32'h00003CFE, 4'h2, 1'b0);
        rchk("width", OFS_BUS_WIDTH, 32'h00003CFF, 1'b0);
        $display("test bus width done");
        wchk(OFS_ACC_STATE, 32'h00005AFF, 4'h3, 1'b0);
        rchk("state", OFS_ACC_STATE, 32'h00005A00, 1'b0);
        chk("area state", 32'h5A, {24'h0, area_three_state});
        wchk(OFS_UPPER_WAIT, 32'hFFFFF5AC, 4'hF, 1'b0);
        wchk(OFS_LOWER_WAIT, 32'h00000123, 4'h3, 1'b0);
        rchk("upper wait", OFS_UPPER_WAIT, 32'h00007524, 1'b0);
        rchk("lower wait", OFS_LOWER_WAIT, 32'h00000123, 1'b0);
        $display("test state and wait done");
        for (int k = 0; k < 8; k++)
            acc(k[2:0]);
        fork
            acc(3'h6);
            wchk(OFS_UPPER_WAIT, 32'h00007124, 4'h3, 1'b0);
        join
        wtab[6] = 3'h1;
        acc(3'h6);
        $display("test access timing done");
        ce <= 1'b0;
        access_start <= 1'b1;
        access_area <= 3'h1;
        repeat (3) @(posedge pclk);
        chk("frozen busy", 32'h0, {31'h0, access_busy});
        access_start <= 1'b0;
        ce <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("frozen start", 32'h0, {31'h0, access_busy});
        $display("test clock enable done");
        // no byte-control areas exist here, so any 8-bit setting is allowed.
        do_reset(1'b0);
        rchk("width", OFS_BUS_WIDTH, 32'h0000FFFF, 1'b0);
        chk("area bus8", 32'hFF, {24'h0, area_bus8});
        $display("test 8-bit boot done");
        complete_run();
    end
    initial
    begin
        repeat (4000) @(posedge pclk);
        fails++;
        complete_run();
    end
endmodule
